/* ring_pkg.sv */
// shared constants for the redundant ring repeater
package ring_pkg;
   localparam int CLK_HZ          = 10_000_000;
   localparam int LED_HOLD_MS     = 300;
   localparam int LED_HOLD_CYC    = (CLK_HZ / 1000) * LED_HOLD_MS;
   localparam int ECHO_WIN_US     = 500;
   localparam int ECHO_WIN_CYC    = (CLK_HZ / 1_000_000) * ECHO_WIN_US;
   localparam int TEST_GAP_US     = 2000;
   localparam int TEST_GAP_CYC    = (CLK_HZ / 1_000_000) * TEST_GAP_US;
   localparam int MISS_LIMIT      = 3;
   localparam int GOOD_LIMIT      = 3;
   localparam int POLL_LIMIT      = 2;
   localparam int CNT_W           = 24;
   localparam int NUM_OPT         = 2;
   localparam logic [1:0] LED_OFF    = 2'h0;
   localparam logic [1:0] LED_YELLOW = 2'h1;
   localparam logic [1:0] LED_RED    = 2'h2;
   localparam logic [1:0] LED_GREEN  = 2'h3;
endpackage

/* ring_link_if.sv */
// frame-level link between the repeater and its partner
`timescale 1ns/1ns
interface ring_link_if;
   logic       elec_rx;
   logic       elec_tx;
   logic [1:0] opt_rx;
   logic [1:0] opt_tx;
   logic [1:0] opt_test;
   logic [1:0] opt_test_ok;
   logic       gap_poll;
   modport repeater (input elec_rx, input opt_rx, input opt_test_ok, input gap_poll,
                     output elec_tx, output opt_tx, output opt_test);
   modport partner  (output elec_rx, output opt_rx, output opt_test_ok, output gap_poll,
                     input elec_tx, input opt_tx, input opt_test);
endinterface

/* ring_repeater.sv */
// repeater end: forwarding, echo, link supervision and indicators
`timescale 1ns/1ns
// How it works
// - repeat each frame from an unsegmented channel to all other unsegmented ones
// - echo optical frames, but not echoes, back on same channel
// - echo leaves led dark, forward lights yellow
// - stretch channel activity at least 300 ms
// - earlier copy forwarded, later copy echo
// - simultaneous copies: first optical channel wins
// - missing echoes segment the fiber link
// - failed module costs only its own stations
// - faults drive red led and fault contact
// - send test frames, lift segmentation when healthy
// - rejoin ring only mid gap poll sequence
// - without gap poll, stay segmented and faulted
// - supervise both optical channels always
// - stations use response delay of 11 bits
// - master retries frames at least 3 times
// - stations leave one address gap below highest
// - master doubles its slot time
// - fault contact opens while error present
module ring_repeater
   import ring_pkg::*;
#(
   parameter int HOLD_CYC = LED_HOLD_CYC,
   parameter int ECHO_CYC = ECHO_WIN_CYC,
   parameter int TEST_CYC = TEST_GAP_CYC
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RESET,
   ring_link_if.repeater   LINK,
   output logic [1:0]      ELEC_LED,
   output logic [1:0]      OPT0_LED,
   output logic [1:0]      OPT1_LED,
   output logic [1:0]      HEALTH_LED,
   output logic            CONTACT_CLOSED,
   output logic [1:0]      SEGMENTED
);

   typedef enum logic [1:0] {
      LK_UP   = 2'b00,
      LK_SEG  = 2'b01,
      LK_WAIT = 2'b10
   } link_e;

   typedef struct packed {
      logic [1:0]             erx_s1;
      logic [1:0]             erx_s2;
      logic [1:0]             orx_s1;
      logic [1:0]             orx_s2;
      logic [1:0]             orx_s3;
      logic [1:0]             ok_s1;
      logic [1:0]             ok_s2;
      logic [1:0]             gp_s;
      logic                   gp_prev;
      logic                   elec_tx;
      logic [1:0]             opt_tx;
      logic [1:0]             opt_test;
      logic [1:0]             wait_echo;
      logic [1:0]             echo_f;
      logic [1:0]             fwd_tx;
      logic [1:0][CNT_W-1:0]  echo_tmr;
      logic [1:0][1:0]        miss;
      logic [1:0][1:0]        good;
      logic [1:0][CNT_W-1:0]  test_tmr;
      link_e [1:0]            lk;
      logic [2:0][CNT_W-1:0]  hold;
      logic [1:0]             polls;
      logic [1:0]             elec_led;
      logic [1:0]             o0_led;
      logic [1:0]             o1_led;
      logic [1:0]             health;
      logic                   contact;
      logic [1:0]             seg;
   } state_s;

   state_s r_q;
   state_s r_d;

   function automatic logic [1:0] led_of(input logic fault, input logic [CNT_W-1:0] h);
      led_of = fault ? LED_RED : ((h != '0) ? LED_YELLOW : LED_OFF);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic       erx;
   logic [1:0] orx;
   logic [1:0] orx_rise;
   logic [1:0] is_echo;
   logic [1:0] is_fwd;
   logic [1:0] cur_echo;
   logic       erx_rise;
   logic       gp_rise;
   logic       any_fault;

   always_comb begin
      r_d      = r_q;
      r_d.erx_s1 = {r_q.erx_s1[0], LINK.elec_rx};
      r_d.erx_s2 = r_q.erx_s1;
      r_d.orx_s1 = LINK.opt_rx;
      r_d.orx_s2 = r_q.orx_s1;
      r_d.orx_s3 = r_q.orx_s2;
      r_d.ok_s1  = LINK.opt_test_ok;
      r_d.ok_s2  = r_q.ok_s1;
      r_d.gp_s   = {r_q.gp_s[0], LINK.gap_poll};
      r_d.gp_prev = r_q.gp_s[1];
      erx      = r_q.erx_s1[1];
      erx_rise = r_q.erx_s1[1] & ~r_q.erx_s2[1];
      orx      = r_q.orx_s2;
      orx_rise = r_q.orx_s2 & ~r_q.orx_s3;
      gp_rise  = r_q.gp_s[1] & ~r_q.gp_prev;
      cur_echo = '0;
      // classify each frame once, at its start, and keep the class to its end
      for (int c = 0; c < NUM_OPT; c++) begin
         if (orx_rise[c]) begin
            cur_echo[c] = r_q.wait_echo[c]
                          || (orx[NUM_OPT-1-c] && !orx_rise[NUM_OPT-1-c]
                              && !r_q.echo_f[NUM_OPT-1-c]);
         end else begin
            cur_echo[c] = r_q.echo_f[c];
         end
      end
      if (orx_rise == 2'h3 && cur_echo == 2'h0) cur_echo[1] = 1'b1;
      is_echo    = orx & cur_echo;
      is_fwd     = orx & ~cur_echo;
      r_d.echo_f = is_echo;
      // forward one source at a time; fiber 0 beats fiber 1, both beat the electrical side
      r_d.elec_tx = 1'b0;
      r_d.opt_tx  = '0;
      if (is_fwd[0] && r_q.lk[0] == LK_UP) begin
         r_d.elec_tx   = 1'b1;
         r_d.opt_tx[1] = (r_q.lk[1] == LK_UP);
      end else if (is_fwd[1] && r_q.lk[1] == LK_UP) begin
         r_d.elec_tx   = 1'b1;
         r_d.opt_tx[0] = (r_q.lk[0] == LK_UP);
      end else if (erx) begin
         r_d.opt_tx = {r_q.lk[1] == LK_UP, r_q.lk[0] == LK_UP};
      end
      // only our own forwarded frames expect an echo back
      r_d.fwd_tx = r_d.opt_tx;
      for (int c = 0; c < NUM_OPT; c++) begin
         if (orx[c] && !is_echo[c]) r_d.opt_tx[c] = 1'b1;
      end
      // echo supervision per fiber
      for (int c = 0; c < NUM_OPT; c++) begin
         if (r_q.fwd_tx[c] && !orx[c]) begin
            r_d.wait_echo[c] = 1'b1;
            r_d.echo_tmr[c]  = CNT_W'(ECHO_CYC);
         end else if (r_q.wait_echo[c]) begin
            if (is_echo[c] && orx_rise[c]) begin
               r_d.wait_echo[c] = 1'b0;
               r_d.miss[c] = '0;
            end else if (r_q.echo_tmr[c] == '0) begin
               r_d.wait_echo[c] = 1'b0;
               if (r_q.miss[c] != 2'(MISS_LIMIT)) r_d.miss[c] = r_q.miss[c] + 2'h1;
            end else begin
               r_d.echo_tmr[c] = r_q.echo_tmr[c] - 1'b1;
            end
         end
      end
      // link state per fiber
      r_d.opt_test = '0;
      for (int c = 0; c < NUM_OPT; c++) begin
         case (r_q.lk[c])
            LK_UP: begin
               if (r_q.miss[c] == 2'(MISS_LIMIT)) begin
                  r_d.lk[c]   = LK_SEG;
                  r_d.good[c] = '0;
               end
            end
            LK_SEG: begin
               if (r_q.test_tmr[c] == '0) begin
                  r_d.opt_test[c] = 1'b1;
                  r_d.test_tmr[c] = CNT_W'(TEST_CYC);
               end else begin
                  r_d.test_tmr[c] = r_q.test_tmr[c] - 1'b1;
               end
               if (r_q.ok_s2[c]) begin
                  if (r_q.good[c] == 2'(GOOD_LIMIT)) r_d.lk[c] = LK_WAIT;
                  else r_d.good[c] = r_q.good[c] + 2'h1;
               end
            end
            LK_WAIT: begin
               if (!r_q.ok_s2[c]) begin
                  r_d.lk[c]   = LK_SEG;
                  r_d.good[c] = '0;
               end else if (r_q.polls == 2'(POLL_LIMIT) && !erx && orx == '0) begin
                  r_d.lk[c]   = LK_UP;
                  r_d.miss[c] = '0;
               end
            end
            default: r_d.lk[c] = LK_SEG;
         endcase
      end
      // gap poll counting; an electrical frame outside a poll breaks the sequence, optical traffic does not
      if (gp_rise) begin
         if (r_q.polls != 2'(POLL_LIMIT)) r_d.polls = r_q.polls + 2'h1;
      end else if (erx_rise && !r_q.gp_s[1]) begin
         r_d.polls = '0;
      end
      if (r_q.lk[0] != LK_WAIT && r_q.lk[1] != LK_WAIT) r_d.polls = '0;
      // indicator stretching
      if (erx_rise) r_d.hold[0] = CNT_W'(HOLD_CYC);
      else if (r_q.hold[0] != '0) r_d.hold[0] = r_q.hold[0] - 1'b1;
      for (int c = 0; c < NUM_OPT; c++) begin
         if (is_fwd[c] && orx_rise[c]) r_d.hold[c+1] = CNT_W'(HOLD_CYC);
         else if (r_q.hold[c+1] != '0) r_d.hold[c+1] = r_q.hold[c+1] - 1'b1;
      end
      any_fault    = (r_q.lk[0] != LK_UP) || (r_q.lk[1] != LK_UP);
      r_d.elec_led = led_of(1'b0, r_q.hold[0]);
      r_d.o0_led   = led_of(r_q.lk[0] != LK_UP, r_q.hold[1]);
      r_d.o1_led   = led_of(r_q.lk[1] != LK_UP, r_q.hold[2]);
      r_d.health   = LED_GREEN;
      r_d.contact  = ~any_fault;
      r_d.seg      = {r_q.lk[1] != LK_UP, r_q.lk[0] != LK_UP};
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign LINK.elec_tx  = r_q.elec_tx;
   assign LINK.opt_tx   = r_q.opt_tx;
   assign LINK.opt_test = r_q.opt_test;
   assign ELEC_LED       = r_q.elec_led;
   assign OPT0_LED       = r_q.o0_led;
   assign OPT1_LED       = r_q.o1_led;
   assign HEALTH_LED     = r_q.health;
   assign CONTACT_CLOSED = r_q.contact;
   assign SEGMENTED      = r_q.seg;

endmodule // ring_repeater

/* ring_partner.sv */
// partner end: peer modules and master seen from the repeater
`timescale 1ns/1ns
module ring_partner
   import ring_pkg::*;
(
   input  wire logic       CORE_CLK,
   input  wire logic       RESET,
   ring_link_if.partner    LINK,
   input  wire logic       ELEC_FRAME,
   input  wire logic [1:0] OPT_FRAME,
   input  wire logic [1:0] FIBER_OK,
   input  wire logic       GAP_POLL,
   output logic            ELEC_SEEN,
   output logic [1:0]      OPT_SEEN
);
   typedef struct packed {
      logic       erx;
      logic [1:0] orx;
      logic [1:0] ok;
      logic       gp;
      logic       eseen;
      logic [1:0] oseen;
      logic [1:0][7:0] hist;
   } state_s;

   state_s r_q;
   state_s r_d;
   logic [1:0] peer_busy;

   // peers echo back what arrives on a healthy fiber, but not the echo of their own
   // recent frame; are master settings
   always_comb begin
      r_d       = r_q;
      peer_busy = '0;
      for (int c = 0; c < NUM_OPT; c++) begin
         r_d.hist[c]  = {r_q.hist[c][6:0], OPT_FRAME[c]};
         peer_busy[c] = OPT_FRAME[c] || (r_q.hist[c] != 8'h0);
      end
      r_d.erx   = ELEC_FRAME;
      r_d.orx   = (OPT_FRAME | (LINK.opt_tx & ~peer_busy)) & FIBER_OK;
      r_d.ok    = FIBER_OK & (LINK.opt_test | r_q.ok);
      r_d.gp    = GAP_POLL;
      r_d.eseen = LINK.elec_tx;
      r_d.oseen = LINK.opt_tx;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign LINK.elec_rx     = r_q.erx;
   assign LINK.opt_rx      = r_q.orx;
   assign LINK.opt_test_ok = r_q.ok;
   assign LINK.gap_poll    = r_q.gp;
   assign ELEC_SEEN        = r_q.eseen;
   assign OPT_SEEN         = r_q.oseen;
endmodule // ring_partner

/* ring_repeater_chk.sv */
// assertions on the link between repeater and partner
`timescale 1ns/1ns
module ring_repeater_chk #(
   parameter int ECHO_CYC = 20
) (
   input wire logic       CORE_CLK,
   input wire logic       RESET,
   input wire logic       elec_rx,
   input wire logic       elec_tx,
   input wire logic [1:0] opt_rx,
   input wire logic [1:0] opt_tx,
   input wire logic [1:0] opt_test,
   input wire logic       gap_poll,
   input wire logic [1:0] SEGMENTED,
   input wire logic       CONTACT_CLOSED
);
   logic [1:0][15:0] quiet_q;
   logic [1:0]       polls_q;
   logic             poll_q;
   // cycles since each fiber last carried our frame; polls seen while segmented
   always_ff @(posedge CORE_CLK) begin
      poll_q <= gap_poll;
      for (int c = 0; c < 2; c++)
         quiet_q[c] <= (RESET || opt_tx[c]) ? 16'h0 : quiet_q[c] + 16'(quiet_q[c] != 16'hFFFF);
      if (RESET || SEGMENTED == 2'h0) polls_q <= 2'h0;
      else if (gap_poll && !poll_q && polls_q != 2'h3) polls_q <= polls_q + 2'h1;
   end
   wire fwd0 = quiet_q[0] > ECHO_CYC + 4;
   wire fwd1 = quiet_q[1] > ECHO_CYC + 4;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////
   elec_fwd_a: assert property ($rose(elec_rx) |-> ##3 (opt_tx | SEGMENTED) == 2'h3)
      else $error("electrical frame not sent on fibers");
   opt0_fwd_a: assert property ($rose(opt_rx[0]) && fwd0 && SEGMENTED == 2'h0 && !$past(opt_rx[1])
      && !$past(elec_rx) |-> ##3 elec_tx && opt_tx == 2'h3)
      else $error("fiber 0 frame not forwarded and echoed");
   opt1_fwd_a: assert property ($rose(opt_rx[1]) && fwd1 && SEGMENTED == 2'h0 && !opt_rx[0]
      && !$past(elec_rx) |-> ##3 elec_tx && opt_tx == 2'h3)
      else $error("fiber 1 frame not forwarded and echoed");
   idle_tx_a: assert property (!elec_rx && opt_rx == 2'h0 |-> ##3 !elec_tx && opt_tx == 2'h0)
      else $error("transmit without a frame");
   fault_contact_a: assert property (SEGMENTED != 2'h0 ##1 SEGMENTED != 2'h0 |-> !CONTACT_CLOSED)
      else $error("contact closed while segmented");
   test_pulse_a: assert property (opt_test[0] |=> !opt_test[0])
      else $error("test pulse too long");
   test_seg_a: assert property (opt_test != 2'h0 |-> (SEGMENTED | $past(SEGMENTED)) != 2'h0)
      else $error("test frame on a closed ring");
   rejoin_poll_a: assert property ($fell(SEGMENTED[0]) || $fell(SEGMENTED[1]) |-> polls_q >= 2'h2)
      else $error("ring closed without gap polls");
   cover property ($rose(SEGMENTED[0]));
   cover property ($fell(SEGMENTED[0]));
   cover property (opt_test[0]);
endmodule // ring_repeater_chk

/* tb_ring_repeater.sv */
// self-checking bench: repeater facing its partner across the link
`timescale 1ns/1ns
module tb_ring_repeater;
   import ring_pkg::*;
   localparam int HOLD = 50, ECHO = 20, TEST = 30;
   logic       core_clk = 1'b0;
   logic       reset = 1'b1;
   logic       elec_frame = 1'b0;
   logic [1:0] opt_frame = 2'h0;
   logic [1:0] fiber_ok = 2'h3;
   logic       gap_poll = 1'b0;
   logic [1:0] elec_led, opt0_led, opt1_led, health_led, segmented, opt_seen;
   logic       contact_closed, elec_seen;
   logic [7:0] got;
   int         n_fail = 0;
   int         tests_run = 0;
   int         seed = 32'h2775;
   int         ch, k;
   always #50 core_clk = ~core_clk;
   ring_link_if link ();
   ring_repeater #(.HOLD_CYC(HOLD), .ECHO_CYC(ECHO), .TEST_CYC(TEST)) u_ring_repeater (.CORE_CLK(core_clk),
      .RESET(reset), .LINK(link), .ELEC_LED(elec_led), .OPT0_LED(opt0_led), .OPT1_LED(opt1_led),
      .HEALTH_LED(health_led), .CONTACT_CLOSED(contact_closed), .SEGMENTED(segmented));
   ring_partner u_ring_partner (.CORE_CLK(core_clk), .RESET(reset), .LINK(link), .ELEC_FRAME(elec_frame),
      .OPT_FRAME(opt_frame), .FIBER_OK(fiber_ok), .GAP_POLL(gap_poll), .ELEC_SEEN(elec_seen), .OPT_SEEN(opt_seen));
   ring_repeater_chk #(.ECHO_CYC(ECHO)) u_ring_repeater_chk (.CORE_CLK(core_clk), .RESET(reset),
      .elec_rx(link.elec_rx), .elec_tx(link.elec_tx), .opt_rx(link.opt_rx), .opt_tx(link.opt_tx),
      .opt_test(link.opt_test), .gap_poll(link.gap_poll), .SEGMENTED(segmented), .CONTACT_CLOSED(contact_closed));
   ////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // indicators {elec, fiber 0, fiber 1}; 3 both at once, 4 fiber 1 one cycle first
   function automatic logic [7:0] exp_leds(input int c);
      return (c == 0) ? {2'h0, LED_YELLOW, 4'h0} : (c == 1 || c == 3) ? {4'h0, LED_YELLOW, 2'h0} : {6'h0, LED_YELLOW};
   endfunction
   task automatic send(input int c, input int n, output logic [7:0] seen);
      seen = 8'h0;
      elec_frame = (c == 0);
      opt_frame = (c == 1) ? 2'h1 : (c == 3) ? 2'h3 : (c != 0) ? 2'h2 : 2'h0;
      for (int i = 0; i < n + 12; i++) begin
         if (i == 1 && c == 4) opt_frame = 2'h3;
         if (i == n) {elec_frame, opt_frame} = 3'h0;
         tick(1);
         seen |= {5'h0, elec_seen, opt_seen};
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      tick(8);
      check({elec_led, opt0_led, opt1_led, health_led}, 8'h0);
      check({segmented, contact_closed}, 8'h0);
      reset = 1'b0;
      tick(3);
      check({health_led, contact_closed}, {LED_GREEN, 1'b1});
      for (int i = 0; i < 12; i++) begin
         ch = (i < 2) ? i + 3 : $unsigned($random(seed)) % 3;
         send(ch, 6 + $unsigned($random(seed)) % 8, got);
         check(got, (ch == 0) ? 8'h3 : 8'h7);
         tick(HOLD - 32);
         check({elec_led, opt0_led, opt1_led}, exp_leds(ch));
         tick(40);
         check({elec_led, opt0_led, opt1_led}, 8'h0);
      end
      fiber_ok = 2'h2;
      repeat (4) begin
         send(0, 6, got);
         tick(ECHO);
      end
      check({segmented, opt0_led, contact_closed}, {2'h1, LED_RED, 1'b0});
      send(0, 6, got);
      check(got[1], 1'b1);
      fiber_ok = 2'h3;
      tick(TEST * 10);
      check({segmented, contact_closed}, {2'h1, 1'b0});
      repeat (2) begin
         gap_poll = 1'b1;
         tick(6);
         gap_poll = 1'b0;
         tick(20);
      end
      for (k = 0; segmented !== 2'h0 && k < 300; k++) tick(1);
      if (k == 300) n_fail++;
      check({segmented, contact_closed, opt0_led}, {2'h0, 1'b1, LED_OFF});
      end_sim();
   end
endmodule // tb_ring_repeater
